// file: core/pvl_consts.vh
`ifndef PVL_CONSTS_VH
`define PVL_CONSTS_VH

// program memory map
`define PVL_ROM_AW        10
`define PVL_RESET_VEC     10'h000
`define PVL_INT_VEC       10'h008
`define PVL_RSVD_FIRST    10'h3FC
`define PVL_STACK_DEPTH   4

// register offsets (byte addresses)
`define PVL_OFF_CTRL      8'h00
`define PVL_OFF_FLAGS     8'h04
`define PVL_OFF_ACC       8'h08
`define PVL_OFF_RBUF      8'h0C
`define PVL_OFF_YIDX      8'h10
`define PVL_OFF_ZIDX      8'h14
`define PVL_OFF_PC        8'h18
`define PVL_OFF_ROM_PTR   8'h1C
`define PVL_OFF_ROM_DATA  8'h20
`define PVL_OFF_INT_STAT  8'h24
`define PVL_OFF_INT_MASK  8'h28

// control register fields
`define PVL_CTRL_DIV_LSB  0
`define PVL_CTRL_DIV_MSB  2
`define PVL_CTRL_RUN      3
`define PVL_CTRL_GIE      4
`define PVL_CTRL_RST      8'h00

// flag register fields
`define PVL_FLG_TO        7
`define PVL_FLG_PD        6
`define PVL_FLG_C         2
`define PVL_FLG_DC        1
`define PVL_FLG_Z         0

// reset-cause codes {timeout_flag_n, powerdown_flag_n}
`define PVL_CAUSE_POR     2'b10
`define PVL_CAUSE_WDT     2'b00
`define PVL_CAUSE_EXT     2'b11

// interrupt status bits
`define PVL_IRQ_BASIC     0
`define PVL_IRQ_EVENT     1
`define PVL_IRQ_EXT       2
`define PVL_IRQ_W         3

// instruction opcodes, word[15:12]
`define PVL_OP_NOP        4'h0
`define PVL_OP_JMP        4'h1
`define PVL_OP_CALL       4'h2
`define PVL_OP_RET        4'h3
`define PVL_OP_INTERRUPT_RETURN       4'h4
`define PVL_OP_PUSH       4'h5
`define PVL_OP_POP        4'h6
`define PVL_OP_ROM_WORD_LOOKUP       4'h7
`define PVL_OP_LDA        4'h8
`define PVL_OP_LDY        4'h9
`define PVL_OP_LDZ        4'hA
`define PVL_OP_INCZ       4'hB
`define PVL_OP_ADDPCL     4'hC
`define PVL_OP_ADDA       4'hD

`endif

// file: core/pvl_rom.v
`default_nettype none
// 1k x 16 program store, registered read
module pvl_rom
(
   input  wire        clk,
   input  wire        we,
   input  wire [9:0]  waddr,
   input  wire [15:0] wdata,
   input  wire [9:0]  raddr,
   output reg  [15:0] rdata
);
   reg [15:0] mem [0:1023];

   always @(posedge clk)
   begin
      if (we)
         mem[waddr] <= wdata;
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

// file: core/pvl_stack.v
`default_nettype none
`include "pvl_consts.vh"
// four-entry return address stack, pointer wraps
module pvl_stack
(
   input  wire       clk,
   input  wire       srst,
   input  wire       push,
   input  wire       pop,
   input  wire [9:0] push_val,
   output wire [9:0] top
);
   reg  [1:0] ptr_r;
   wire [9:0] ent [0:`PVL_STACK_DEPTH-1];
   wire [1:0] top_idx;

   assign top_idx = ptr_r - 2'd1;
   assign top     = ent[top_idx];

   always @(posedge clk)
   begin
      if (srst)
         ptr_r <= 2'd0;
      else if (push)
         ptr_r <= ptr_r + 2'd1;
      else if (pop)
         ptr_r <= top_idx;
   end

   genvar i;
   generate
      for (i = 0; i < `PVL_STACK_DEPTH; i = i + 1)
      begin : g_ent
         reg [9:0] val_r;
         always @(posedge clk)
         begin
            if (srst)
               val_r <= 10'h000;
            else if (push && ptr_r == i)
               val_r <= push_val;
         end
         assign ent[i] = val_r;
      end
   endgenerate
endmodule
`default_nettype wire

// file: core/pvl_core.v
// Our own choices: the address map and the address-and-strobe port.
`default_nettype none
`include "pvl_consts.vh"
module pvl_core
(
   input  wire        clk,
   input  wire        srst,
   input  wire        ext_rst_n,
   input  wire        wdt_ovf,
   input  wire        basic_timer_evt,
   input  wire        event_timer_evt,
   input  wire        external_irq_pin,
   input  wire [7:0]  addr,
   input  wire [31:0] wr_data,
   input  wire        wr_en,
   input  wire        rd_en,
   output reg  [31:0] rd_data,
   output reg         irq,
   output reg  [9:0]  pc_out,
   output reg         instr_tick
);
   localparam ST_BOOT = 2'b00;
   localparam ST_EXEC = 2'b01;
   localparam ST_ROM_WORD_LOOKUP = 2'b10;

   reg  [1:0]  st_r, st_nxt;
   reg  [9:0]  pc_nxt;
   reg  [7:0]  acc_r, acc_nxt, rb_r, rb_nxt, y_r, y_nxt, z_r, z_nxt;
   reg  [2:0]  flg_r, flg_nxt, sv_flg_r, sv_flg_nxt;
   reg  [7:0]  sv_acc_r, sv_acc_nxt;
   reg         gie_r, gie_nxt;
   reg  [1:0]  cause_r;
   reg         run_r;
   reg  [2:0]  div_sel_r;
   reg  [3:0]  div_cnt_r, div_last;
   reg  [`PVL_IRQ_W-1:0] stat_r, mask_r, evt;
   reg         pin_d_r;
   reg  [9:0]  rom_ptr_r, rom_raddr;
   reg         push, pop;
   reg  [9:0]  push_val;
   reg  [8:0]  sum9;
   reg  [4:0]  sum_lo;

   wire        sys_rst;
   wire        tick;
   wire        take_irq;
   wire [15:0] rom_q;
   wire [9:0]  stk_top;
   wire [9:0]  pc_inc;
   wire [3:0]  op;
   wire [7:0]  imm;
   wire        wr_rom;
   wire        rd_stat;

   assign sys_rst  = srst | wdt_ovf | ~ext_rst_n;
   assign pc_inc   = pc_out + 10'h001;
   assign op       = rom_q[15:12];
   assign imm      = rom_q[7:0];
   assign take_irq = gie_r & (|(stat_r & mask_r));
   assign wr_rom   = wr_en && addr == `PVL_OFF_ROM_DATA && rom_ptr_r < `PVL_RSVD_FIRST;
   assign rd_stat  = rd_en && addr == `PVL_OFF_INT_STAT;

   // divide ratio 1,2,4,8,16
   always @*
   begin
      case (div_sel_r)
         3'd0:    div_last = 4'h0;
         3'd1:    div_last = 4'h1;
         3'd2:    div_last = 4'h3;
         3'd3:    div_last = 4'h7;
         default: div_last = 4'hF;
      endcase
   end
   assign tick = run_r && div_cnt_r == div_last;

   pvl_rom u_rom
   (
      .clk   (clk),
      .we    (wr_rom),
      .waddr (rom_ptr_r),
      .wdata (wr_data[15:0]),
      .raddr (rom_raddr),
      .rdata (rom_q)
   );

   pvl_stack u_stk
   (
      .clk      (clk),
      .srst     (sys_rst),
      .push     (push),
      .pop      (pop),
      .push_val (push_val),
      .top      (stk_top)
   );

   // instruction execution
   always @*
   begin
      st_nxt     = st_r;
      pc_nxt     = pc_out;
      acc_nxt    = acc_r;
      rb_nxt     = rb_r;
      y_nxt      = y_r;
      z_nxt      = z_r;
      flg_nxt    = flg_r;
      sv_acc_nxt = sv_acc_r;
      sv_flg_nxt = sv_flg_r;
      gie_nxt    = gie_r;
      push       = 1'b0;
      pop        = 1'b0;
      push_val   = pc_inc;
      sum9       = {1'b0, pc_inc[7:0]} + {1'b0, acc_r};
      sum_lo     = {1'b0, acc_r[3:0]} + {1'b0, imm[3:0]};
      case (st_r)
         ST_BOOT:
            st_nxt = ST_EXEC;
         ST_EXEC:
         begin
            if (tick && take_irq)
            begin
               push     = 1'b1;
               push_val = pc_out;
               pc_nxt   = `PVL_INT_VEC;
               gie_nxt  = 1'b0;
            end
            else if (tick)
            begin
               pc_nxt = pc_inc;
               case (op)
                  `PVL_OP_JMP:
                     pc_nxt = rom_q[9:0];
                  `PVL_OP_CALL:
                  begin
                     push   = 1'b1;
                     pc_nxt = rom_q[9:0];
                  end
                  `PVL_OP_RET:
                  begin
                     pop    = 1'b1;
                     pc_nxt = stk_top;
                  end
                  `PVL_OP_INTERRUPT_RETURN:
                  begin
                     pop     = 1'b1;
                     pc_nxt  = stk_top;
                     gie_nxt = 1'b1;
                  end
                  `PVL_OP_PUSH:
                  begin
                     sv_acc_nxt = acc_r;
                     sv_flg_nxt = flg_r;
                  end
                  `PVL_OP_POP:
                  begin
                     acc_nxt = sv_acc_r;
                     flg_nxt = sv_flg_r;
                  end
                  `PVL_OP_ROM_WORD_LOOKUP:
                     st_nxt = ST_ROM_WORD_LOOKUP;
                  `PVL_OP_LDA:
                     acc_nxt = imm;
                  `PVL_OP_LDY:
                     y_nxt = imm;
                  `PVL_OP_LDZ:
                     z_nxt = imm;
                  `PVL_OP_INCZ:
                  begin
                     z_nxt = z_r + 8'h01;
                     flg_nxt[`PVL_FLG_Z] = (z_r == 8'hFF);
                  end
                  `PVL_OP_ADDPCL:
                     pc_nxt = {pc_inc[9:8] + {1'b0, sum9[8]}, sum9[7:0]};
                  `PVL_OP_ADDA:
                  begin
                     {flg_nxt[`PVL_FLG_C], acc_nxt} = {1'b0, acc_r} + {1'b0, imm};
                     flg_nxt[`PVL_FLG_DC] = sum_lo[4];
                     flg_nxt[`PVL_FLG_Z]  = ((acc_r + imm) == 8'h00);
                  end
                  default:
                     pc_nxt = pc_inc;
               endcase
            end
         end
         ST_ROM_WORD_LOOKUP:
         begin
            if (tick)
            begin
               acc_nxt = rom_q[7:0];
               rb_nxt  = rom_q[15:8];
               st_nxt  = ST_EXEC;
            end
         end
         default:
            st_nxt = ST_BOOT;
      endcase
      if (st_nxt == ST_ROM_WORD_LOOKUP)
         rom_raddr = {y_r[1:0], z_r};
      else
         rom_raddr = pc_nxt;
   end

   // interrupt event sources
   always @*
   begin
      evt = {`PVL_IRQ_W{1'b0}};
      evt[`PVL_IRQ_BASIC] = basic_timer_evt;
      evt[`PVL_IRQ_EVENT] = event_timer_evt;
      evt[`PVL_IRQ_EXT]   = external_irq_pin & ~pin_d_r;
   end

   // reset cause flags survive the resets they record
   always @(posedge clk)
   begin
      if (srst)
         cause_r <= `PVL_CAUSE_POR;
      else if (wdt_ovf)
         cause_r <= `PVL_CAUSE_WDT;
      else if (!ext_rst_n)
         cause_r <= `PVL_CAUSE_EXT;
   end

   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         st_r       <= ST_BOOT;
         pc_out     <= `PVL_RESET_VEC;
         acc_r      <= 8'h00;
         rb_r       <= 8'h00;
         y_r        <= 8'h00;
         z_r        <= 8'h00;
         flg_r      <= 3'h0;
         sv_acc_r   <= 8'h00;
         sv_flg_r   <= 3'h0;
         gie_r      <= 1'b0;
         run_r      <= 1'b0;
         div_sel_r  <= 3'h0;
         div_cnt_r  <= 4'h0;
         stat_r     <= {`PVL_IRQ_W{1'b0}};
         mask_r     <= {`PVL_IRQ_W{1'b0}};
         pin_d_r    <= 1'b0;
         rom_ptr_r  <= 10'h000;
         rd_data    <= 32'h0000_0000;
         irq        <= 1'b0;
         instr_tick <= 1'b0;
      end
      else
      begin
         st_r       <= st_nxt;
         pc_out     <= pc_nxt;
         acc_r      <= acc_nxt;
         rb_r       <= rb_nxt;
         y_r        <= y_nxt;
         z_r        <= z_nxt;
         flg_r      <= flg_nxt;
         sv_acc_r   <= sv_acc_nxt;
         sv_flg_r   <= sv_flg_nxt;
         gie_r      <= gie_nxt;
         pin_d_r    <= external_irq_pin;
         instr_tick <= tick;
         div_cnt_r  <= (tick || !run_r) ? 4'h0 : div_cnt_r + 4'h1;
         // read clears, a new event in the same cycle wins
         stat_r     <= (rd_stat ? {`PVL_IRQ_W{1'b0}} : stat_r) | evt;
         irq        <= |(((rd_stat ? {`PVL_IRQ_W{1'b0}} : stat_r) | evt) & mask_r);
         if (rd_en)
         begin
            case (addr)
               `PVL_OFF_CTRL:
                  rd_data <= {27'h000_0000, gie_r, run_r, div_sel_r};
               `PVL_OFF_FLAGS:
                  rd_data <= {24'h00_0000, cause_r, 3'h0, flg_r};
               `PVL_OFF_ACC:
                  rd_data <= {24'h00_0000, acc_r};
               `PVL_OFF_RBUF:
                  rd_data <= {24'h00_0000, rb_r};
               `PVL_OFF_YIDX:
                  rd_data <= {24'h00_0000, y_r};
               `PVL_OFF_ZIDX:
                  rd_data <= {24'h00_0000, z_r};
               `PVL_OFF_PC:
                  rd_data <= {22'h00_0000, pc_out};
               `PVL_OFF_ROM_PTR:
                  rd_data <= {22'h00_0000, rom_ptr_r};
               `PVL_OFF_INT_STAT:
                  rd_data <= {29'h0000_0000, stat_r};
               `PVL_OFF_INT_MASK:
                  rd_data <= {29'h0000_0000, mask_r};
               default:
                  rd_data <= 32'h0000_0000;
            endcase
         end
         else
            rd_data <= 32'h0000_0000;
         if (wr_en)
         begin
            case (addr)
               `PVL_OFF_CTRL:
               begin
                  div_sel_r <= wr_data[`PVL_CTRL_DIV_MSB:`PVL_CTRL_DIV_LSB];
                  run_r     <= wr_data[`PVL_CTRL_RUN];
                  gie_r     <= wr_data[`PVL_CTRL_GIE];
                  div_cnt_r <= 4'h0;
               end
               `PVL_OFF_FLAGS:
                  flg_r <= wr_data[2:0];
               `PVL_OFF_ACC:
                  acc_r <= wr_data[7:0];
               `PVL_OFF_RBUF:
                  rb_r <= wr_data[7:0];
               `PVL_OFF_YIDX:
                  y_r <= wr_data[7:0];
               `PVL_OFF_ZIDX:
                  z_r <= wr_data[7:0];
               `PVL_OFF_ROM_PTR:
                  rom_ptr_r <= wr_data[9:0];
               `PVL_OFF_ROM_DATA:
                  rom_ptr_r <= rom_ptr_r + 10'h001;
               `PVL_OFF_INT_MASK:
                  mask_r <= wr_data[`PVL_IRQ_W-1:0];
               default:
                  rom_ptr_r <= rom_ptr_r;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/pvl_core_properties.sv
`default_nettype none
`include "pvl_consts.vh"
module pvl_core_properties
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        ext_rst_n,
   input wire logic        wdt_ovf,
   input wire logic        basic_timer_evt,
   input wire logic        event_timer_evt,
   input wire logic        external_irq_pin,
   input wire logic [7:0]  addr,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [31:0] rd_data,
   input wire logic        irq,
   input wire logic [9:0]  pc_out,
   input wire logic        instr_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       pin_d_r;
   logic [4:0] gap_r;
   logic [1:0] seen_r;
   wire        cause;

   assign cause = basic_timer_evt | event_timer_evt | (external_irq_pin & ~pin_d_r) | wr_en;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // cycles since last tick, ticks seen since a write
   always_ff @(posedge clk)
   begin
      pin_d_r <= external_irq_pin;
      if (srst | wdt_ovf | ~ext_rst_n | wr_en)
      begin
         gap_r  <= 5'h00;
         seen_r <= 2'h0;
      end
      else if (instr_tick)
      begin
         gap_r <= 5'h01;
         if (seen_r != 2'h3)
            seen_r <= seen_r + 2'h1;
      end
      else if (gap_r != 5'h1F)
         gap_r <= gap_r + 5'h01;
   end

   sequence stat_read_s;
      rd_en && addr == `PVL_OFF_INT_STAT && !cause;
   endsequence

   sequence quiet_s;
      !cause;
   endsequence

   a_wdt_clears_pc: assert property (wdt_ovf |=> pc_out == 10'h000 && !irq)
      else $error("watchdog reset left pc or irq set");
   a_release_outputs: assert property ($fell(srst) |-> pc_out == 10'h000 && !instr_tick)
      else $error("outputs not clear after reset release");
   a_pin_reset_pc: assert property (!ext_rst_n |=> pc_out == 10'h000)
      else $error("external reset pin did not clear pc");
   a_pc_moves_tick: assert property (($changed(pc_out) && pc_out != 10'h000) |-> instr_tick)
      else $error("pc moved without an instruction tick");
   a_pc_not_reserved: assert property (pc_out < `PVL_RSVD_FIRST)
      else $error("pc entered the reserved area");
   a_irq_has_cause: assert property ($rose(irq) |-> $past(cause) || $past(cause, 2))
      else $error("irq rose without an event or mask write");
   a_stat_read_clears: assert property (stat_read_s ##1 quiet_s |=> !irq)
      else $error("irq stayed high after status read");
   a_tick_ratio: assert property ((instr_tick && seen_r == 2'h3) |->
      gap_r inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10})
      else $error("instruction tick spacing not a legal ratio");
   a_read_one_cycle: assert property (!rd_en |=> rd_data == 32'h0000_0000)
      else $error("read data outside its cycle");
endmodule
`default_nettype wire

// file: tb/pvl_core_bench.sv
`default_nettype none
`include "pvl_consts.vh"
module pvl_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk       = 1'b0;
   logic [2:0]  rst_sel   = 3'h1;
   logic [2:0]  ev        = 3'h0;
   logic [7:0]  addr      = 8'h00;
   logic [31:0] wr_data   = 32'h0000_0000;
   logic        wr_en     = 1'b0;
   logic        rd_en     = 1'b0;
   int          n;
   int          err_count = 0;
   int          checked   = 0;
   logic [31:0] cause_exp [3] = '{32'h0000_0080, 32'h0000_0000, 32'h0000_00C0};
   wire  [31:0] rd_data;
   wire         irq;
   wire  [9:0]  pc_out;
   wire         instr_tick;

   always #2 clk = ~clk;

   pvl_core DUT
   (
      .clk              (clk),
      .srst             (rst_sel[0]),
      .wdt_ovf          (rst_sel[1]),
      .ext_rst_n        (~rst_sel[2]),
      .basic_timer_evt  (ev[0]),
      .event_timer_evt  (ev[1]),
      .external_irq_pin (ev[2]),
      .addr             (addr),
      .wr_data          (wr_data),
      .wr_en            (wr_en),
      .rd_en            (rd_en),
      .rd_data          (rd_data),
      .irq              (irq),
      .pc_out           (pc_out),
      .instr_tick       (instr_tick)
   );

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge clk);
      wr_en   <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk(nm, e, rd_data);
   endtask

   task automatic ld(input logic [9:0] a, input logic [15:0] w);
      wr(`PVL_OFF_ROM_PTR, {22'h00_0000, a});
      wr(`PVL_OFF_ROM_DATA, {16'h0000, w});
   endtask

   task automatic fire(input int s);
      @(posedge clk);
      ev <= 3'h1 << s;
      @(posedge clk);
      ev <= 3'h0;
   endtask

   task automatic wait_pc(input logic [9:0] p);
      n = 0;
      while (pc_out !== p && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      chk("pc", 32'(p), 32'(pc_out));
   endtask

   task automatic wait_tick;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (instr_tick !== 1'b1 && n < 64);
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      #40000;
      err_count++;
      print_verdict();
   end

   initial
   begin
      repeat (12) @(posedge clk);
      rst_sel <= 3'h0;
      rchk(`PVL_OFF_FLAGS, 32'h0000_0080, "power-on flags");
      chk("pc at reset", 32'h0000_0000, 32'(pc_out));
      rchk(8'hFC, 32'h0000_0000, "unmapped read");
      wr(`PVL_OFF_ROM_PTR, 32'h0000_03FB);
      wr(`PVL_OFF_ROM_DATA, 32'h0000_0000);
      wr(`PVL_OFF_ROM_DATA, 32'h0000_0000);
      rchk(`PVL_OFF_ROM_PTR, 32'h0000_03FD, "rom pointer");
      $display("test map done");
      // lookup at 0x1ff, z wrap, call, pc add with carry
      ld(10'h000, 16'h9001);
      ld(10'h001, 16'hA0FF);
      ld(10'h002, 16'h7000);
      ld(10'h003, 16'hB000);
      ld(10'h004, 16'h2010);
      ld(10'h005, 16'hC000);
      ld(10'h010, 16'h3000);
      ld(10'h102, 16'h1102);
      ld(10'h1FF, 16'h51FC);
      // service: save, clobber, restore, return
      ld(10'h008, 16'h5000);
      ld(10'h009, 16'h8008);
      ld(10'h00A, 16'hD0F8);
      ld(10'h00B, 16'h6000);
      ld(10'h00C, 16'h4000);
      wr(`PVL_OFF_CTRL, 32'h0000_0018);
      wait_pc(10'h102);
      rchk(`PVL_OFF_ACC, 32'h0000_00FC, "acc");
      rchk(`PVL_OFF_RBUF, 32'h0000_0051, "r buffer");
      rchk(`PVL_OFF_YIDX, 32'h0000_0001, "y index");
      rchk(`PVL_OFF_ZIDX, 32'h0000_0000, "z index");
      rchk(`PVL_OFF_PC, 32'h0000_0102, "pc register");
      $display("test program done");
      for (int s = 0; s < 3; s++)
      begin
         wr(`PVL_OFF_INT_MASK, 32'h0000_0001 << s);
         fire(s);
         wait_pc(`PVL_INT_VEC);
         chk("irq", 32'h0000_0001, 32'(irq));
         rchk(`PVL_OFF_INT_STAT, 32'h0000_0001 << s, "status");
         wait_pc(10'h102);
         rchk(`PVL_OFF_ACC, 32'h0000_00FC, "acc restored");
         rchk(`PVL_OFF_FLAGS, 32'h0000_0081, "flags restored");
      end
      wr(`PVL_OFF_INT_MASK, 32'h0000_0000);
      fire(1);
      repeat (4) @(negedge clk);
      chk("masked irq", 32'h0000_0000, 32'(irq));
      rchk(`PVL_OFF_INT_STAT, 32'h0000_0002, "masked status");
      chk("pc masked", 32'h0000_0102, 32'(pc_out));
      $display("test interrupt done");
      for (int s = 0; s < 5; s++)
      begin
         wr(`PVL_OFF_CTRL, 32'h0000_0008 | 32'(s));
         repeat (4) wait_tick();
         chk("tick gap", 32'h0000_0001 << s, n);
      end
      $display("test divider done");
      for (int r = 0; r < 3; r++)
      begin
         @(posedge clk);
         rst_sel <= 3'h1 << r;
         @(posedge clk);
         rst_sel <= 3'h0;
         rchk(`PVL_OFF_FLAGS, cause_exp[r], "cause flags");
         rchk(`PVL_OFF_ACC, 32'h0000_0000, "acc default");
         chk("pc after reset", 32'h0000_0000, 32'(pc_out));
      end
      wr(`PVL_OFF_CTRL, 32'h0000_0008);
      wait_pc(10'h102);
      $display("test reset done");
      print_verdict();
   end
endmodule

bind pvl_core pvl_core_properties u_props
(
   .clk              (clk),
   .srst             (srst),
   .ext_rst_n        (ext_rst_n),
   .wdt_ovf          (wdt_ovf),
   .basic_timer_evt  (basic_timer_evt),
   .event_timer_evt  (event_timer_evt),
   .external_irq_pin (external_irq_pin),
   .addr             (addr),
   .wr_en            (wr_en),
   .rd_en            (rd_en),
   .rd_data          (rd_data),
   .irq              (irq),
   .pc_out           (pc_out),
   .instr_tick       (instr_tick)
);
`default_nettype wire
